// file: shared/sprqd_pkg.sv
package sprqd_pkg;
    // Requester native width codes
    localparam logic [1:0] WIDTH_32 = 2'h0;
    localparam logic [1:0] WIDTH_64 = 2'h1;
    localparam logic [1:0] WIDTH_128 = 2'h2;
    localparam logic [1:0] WIDTH_BAD = 2'h3;
    // Transfer size and type codes
    localparam logic [3:0] SIZE_SINGLE = 4'h0;
    localparam logic [3:0] SIZE_LINE4 = 4'h1;
    localparam logic [3:0] SIZE_LINE8 = 4'h2;
    localparam logic [3:0] SIZE_LINE16 = 4'h3;
    localparam logic [3:0] SIZE_BURST_WORD = 4'ha;
    localparam logic [3:0] SIZE_BURST_DWORD = 4'hb;
    // Words per cache line
    localparam logic [4:0] LINE4_WORDS = 5'h04;
    localparam logic [4:0] LINE8_WORDS = 5'h08;
    localparam logic [4:0] LINE16_WORDS = 5'h10;
    // Burst unit count field in byte_enable, bit 15 is the first lane
    localparam int BURST_COUNT_MSB = 15;
    localparam int BURST_COUNT_LSB = 12;
    // Attribute bit positions
    localparam int ATTR_WRITE_THROUGH = 0;
    localparam int ATTR_CACHE_INHIBIT = 1;
    localparam int ATTR_COHERENT = 2;
    localparam int ATTR_GUARDED = 3;
    localparam int ATTR_USER0 = 4;
    localparam int ATTR_USER2 = 6;
    localparam int ATTR_WIDTH = 7;
    // Outstanding command limits per direction
    localparam logic [2:0] MAX_READS = 3'h4;
    localparam logic [2:0] MAX_WRITES = 3'h4;
    // Reset values
    localparam logic [4:0] BEATS_RESET = 5'h00;
    localparam logic [2:0] COUNT_RESET = 3'h0;

    typedef enum logic [2:0] {
        SPRQD_KIND_SINGLE = 3'b001,
        SPRQD_KIND_LINE = 3'b010,
        SPRQD_KIND_BURST = 3'b100
    } sprqd_kind_t;
endpackage

// file: shared/sprqd_if.sv
`timescale 1ns/1ns
interface sprqd_if;
    logic [1:0] requester_index;
    logic [1:0] requester_width;
    logic primary_addr_valid;
    logic secondary_addr_valid;
    logic read_not_write;
    logic [3:0] transfer_size_code;
    logic [15:0] byte_enable;
    logic [6:0] requester_transfer_attribute;
    logic read_burst_active;
    logic read_promote;
    logic [1:0] read_pending_priority;
    logic read_pending_request;
    logic [1:0] request_priority;
    logic address_acknowledge;
    logic address_error;
    logic read_data_ack;

    modport port_end (
        input requester_index,
        input requester_width,
        input primary_addr_valid,
        input secondary_addr_valid,
        input read_not_write,
        input transfer_size_code,
        input byte_enable,
        input requester_transfer_attribute,
        input read_burst_active,
        input read_promote,
        input read_pending_priority,
        input read_pending_request,
        input request_priority,
        output address_acknowledge,
        output address_error,
        output read_data_ack
    );

    modport arbiter_end (
        output requester_index,
        output requester_width,
        output primary_addr_valid,
        output secondary_addr_valid,
        output read_not_write,
        output transfer_size_code,
        output byte_enable,
        output requester_transfer_attribute,
        output read_burst_active,
        output read_promote,
        output read_pending_priority,
        output read_pending_request,
        output request_priority,
        input address_acknowledge,
        input address_error,
        input read_data_ack
    );
endinterface

// file: hw/sprqd_port.sv
// Contract
// - Two-bit requester index, four requesters maximum
// - Width code 00/01/10 is 32/64/128, 11 illegal
// - Qualifiers meaningful only with primary valid; sampled here under secondary valid too
// - Burst read indicator drops on final beat
// - Promote makes oldest acked secondary read primary
// - Secondary valid only with valid pipelined address
// - Size 0000: single unit, byte enables select
// - Sizes 0001/0010/0011: 4/8/16-word cache lines
// - Sizes 1010/1011: word/doubleword burst, count upper BE
// - Attribute bits 0-3: W, I, M, G
// - Attribute bits 4-6: U0, U1, U2
// - Pending priority, pending request, priority ignored
// - Acknowledge cycle after sampling matching request
// - Pipelining: four reads, four writes outstanding
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
module sprqd_port #(
    parameter int SEC_DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    sprqd_if.port_end link,
    input wire logic pipeline_enable,
    input wire logic read_beat,
    input wire logic write_retire,
    output logic req_valid,
    output logic req_error,
    output logic req_is_read,
    output logic req_secondary,
    output logic [1:0] req_index,
    output logic [1:0] req_width,
    output sprqd_pkg::sprqd_kind_t req_kind,
    output logic [4:0] req_beats,
    output logic [15:0] req_byte_en,
    output logic req_write_through,
    output logic req_cache_inhibit,
    output logic req_coherent,
    output logic req_guarded,
    output logic [2:0] req_user_attr,
    output logic primary_read_busy,
    output logic [2:0] reads_outstanding,
    output logic [2:0] writes_outstanding
);
    typedef enum logic [1:0] {
        SPRQD_RD_IDLE = 2'b01,
        SPRQD_RD_BUSY = 2'b10
    } sprqd_rd_t;

    ////////////////////////////////////////////////////////////////////////////
    // Request decode
    logic sample_primary;
    logic sample_secondary;
    logic sample_any;
    logic bad_code;
    logic accept;
    logic [4:0] beats;
    logic [4:0] line_words;
    sprqd_pkg::sprqd_kind_t kind;
    logic [2:0] rd_cnt;
    logic [2:0] wr_cnt;
    logic ack_r;
    logic err_r;
    logic fifo_full;
    sprqd_rd_t rd_state_r;

    // Inputs are looked at only under a valid strobe; no answer-cycle resample
    assign sample_primary = link.primary_addr_valid && !ack_r && !err_r;
    assign sample_secondary = link.secondary_addr_valid && !ack_r && !err_r
        && pipeline_enable && !link.primary_addr_valid;
    assign sample_any = sample_primary || sample_secondary;

    always_comb begin
        kind = sprqd_pkg::SPRQD_KIND_SINGLE;
        line_words = sprqd_pkg::LINE4_WORDS;
        beats = 5'h01;
        bad_code = link.requester_width == sprqd_pkg::WIDTH_BAD;
        unique case (link.transfer_size_code)
            sprqd_pkg::SIZE_SINGLE: begin
                kind = sprqd_pkg::SPRQD_KIND_SINGLE;
            end
            sprqd_pkg::SIZE_LINE4, sprqd_pkg::SIZE_LINE8, sprqd_pkg::SIZE_LINE16: begin
                kind = sprqd_pkg::SPRQD_KIND_LINE;
                if (link.transfer_size_code == sprqd_pkg::SIZE_LINE8) begin
                    line_words = sprqd_pkg::LINE8_WORDS;
                end else if (link.transfer_size_code == sprqd_pkg::SIZE_LINE16) begin
                    line_words = sprqd_pkg::LINE16_WORDS;
                end
                unique case (link.requester_width)
                    sprqd_pkg::WIDTH_64: beats = line_words >> 1;
                    sprqd_pkg::WIDTH_128: beats = line_words >> 2;
                    default: beats = line_words;
                endcase
            end
            sprqd_pkg::SIZE_BURST_WORD, sprqd_pkg::SIZE_BURST_DWORD: begin
                kind = sprqd_pkg::SPRQD_KIND_BURST;
                beats = {1'b0, link.byte_enable[sprqd_pkg::BURST_COUNT_MSB:
                    sprqd_pkg::BURST_COUNT_LSB]} + 5'h01;
            end
            default: begin
                bad_code = 1'b1;
            end
        endcase
    end

    // Room check per direction; a busy primary slot defers a primary read
    always_comb begin
        if (link.read_not_write) begin
            accept = rd_cnt < sprqd_pkg::MAX_READS && !fifo_full
                && !(sample_primary && (rd_state_r == SPRQD_RD_BUSY || pop));
        end else begin
            accept = wr_cnt < sprqd_pkg::MAX_WRITES;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge and decoded output registers
    logic ack_nxt;
    logic err_nxt;
    logic is_read_r;
    logic sec_r;
    logic [1:0] index_r;
    logic [1:0] width_r;
    sprqd_pkg::sprqd_kind_t kind_r;
    logic [4:0] beats_r;
    logic [15:0] be_r;
    logic [6:0] attr_r;

    always_comb begin
        ack_nxt = sample_any && !bad_code && accept;
        err_nxt = sample_any && bad_code;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            is_read_r <= 1'b0;
            sec_r <= 1'b0;
            index_r <= 2'h0;
            width_r <= 2'h0;
            kind_r <= sprqd_pkg::SPRQD_KIND_SINGLE;
            beats_r <= sprqd_pkg::BEATS_RESET;
            be_r <= 16'h0000;
            attr_r <= 7'h00;
        end else begin
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            if (sample_any) begin
                is_read_r <= link.read_not_write;
                sec_r <= sample_secondary;
                index_r <= link.requester_index;
                width_r <= link.requester_width;
                kind_r <= kind;
                beats_r <= beats;
                be_r <= link.byte_enable;
                attr_r <= link.requester_transfer_attribute;
            end
        end
    end

    assign link.address_acknowledge = ack_r;
    assign link.address_error = err_r;
    assign req_valid = ack_r;
    assign req_error = err_r;
    assign req_is_read = is_read_r;
    assign req_secondary = sec_r;
    assign req_index = index_r;
    assign req_width = width_r;
    assign req_kind = kind_r;
    assign req_beats = beats_r;
    assign req_byte_en = be_r;
    assign req_write_through = attr_r[sprqd_pkg::ATTR_WRITE_THROUGH];
    assign req_cache_inhibit = attr_r[sprqd_pkg::ATTR_CACHE_INHIBIT];
    assign req_coherent = attr_r[sprqd_pkg::ATTR_COHERENT];
    assign req_guarded = attr_r[sprqd_pkg::ATTR_GUARDED];
    assign req_user_attr = attr_r[sprqd_pkg::ATTR_USER2:sprqd_pkg::ATTR_USER0];
    // Priority and pending-read hints from the arbiter have no load here

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledged secondary reads, oldest first
    logic [4:0] fifo_mem [SEC_DEPTH];
    logic [$clog2(SEC_DEPTH)-1:0] head_r;
    logic [$clog2(SEC_DEPTH)-1:0] head_nxt;
    logic [$clog2(SEC_DEPTH)-1:0] tail_r;
    logic [$clog2(SEC_DEPTH)-1:0] tail_nxt;
    logic [$clog2(SEC_DEPTH):0] fill_r;
    logic [$clog2(SEC_DEPTH):0] fill_nxt;
    logic push;
    logic pop;
    logic rd_done;

    assign fifo_full = fill_r == ($clog2(SEC_DEPTH) + 1)'(SEC_DEPTH);
    assign push = ack_r && is_read_r && sec_r;
    assign pop = link.read_promote && fill_r != '0 && rd_state_r == SPRQD_RD_IDLE
        && !(ack_r && is_read_r && !sec_r);
    always_comb begin
        head_nxt = pop ? head_r + 1'b1 : head_r;
        tail_nxt = push ? tail_r + 1'b1 : tail_r;
        fill_nxt = fill_r + {{$clog2(SEC_DEPTH){1'b0}}, push}
            - {{$clog2(SEC_DEPTH){1'b0}}, pop};
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            head_r <= '0;
            tail_r <= '0;
            fill_r <= '0;
        end else begin
            head_r <= head_nxt;
            tail_r <= tail_nxt;
            fill_r <= fill_nxt;
            if (push) begin
                fifo_mem[tail_r] <= beats_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Primary read beats
    sprqd_rd_t rd_state_nxt;
    logic [4:0] left_r;
    logic [4:0] left_nxt;
    logic dack_r;
    logic dack_nxt;

    always_comb begin
        rd_state_nxt = rd_state_r;
        left_nxt = left_r;
        dack_nxt = 1'b0;
        rd_done = 1'b0;
        unique case (rd_state_r)
            SPRQD_RD_IDLE: begin
                if (ack_r && is_read_r && !sec_r) begin
                    rd_state_nxt = SPRQD_RD_BUSY;
                    left_nxt = beats_r;
                end else if (pop) begin
                    rd_state_nxt = SPRQD_RD_BUSY;
                    left_nxt = fifo_mem[head_r];
                end
            end
            SPRQD_RD_BUSY: begin
                if (read_beat) begin
                    dack_nxt = 1'b1;
                    left_nxt = left_r - 5'h01;
                    if (left_r == 5'h01) begin
                        rd_state_nxt = SPRQD_RD_IDLE;
                        rd_done = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_state_r <= SPRQD_RD_IDLE;
            left_r <= sprqd_pkg::BEATS_RESET;
            dack_r <= 1'b0;
        end else begin
            rd_state_r <= rd_state_nxt;
            left_r <= left_nxt;
            dack_r <= dack_nxt;
        end
    end

    assign link.read_data_ack = dack_r;
    assign primary_read_busy = rd_state_r == SPRQD_RD_BUSY;

    ////////////////////////////////////////////////////////////////////////////
    // Outstanding command counts
    logic [2:0] rd_cnt_nxt;
    logic [2:0] wr_cnt_nxt;

    always_comb begin
        rd_cnt_nxt = rd_cnt + {2'h0, ack_r && is_read_r} - {2'h0, rd_done};
        wr_cnt_nxt = wr_cnt + {2'h0, ack_r && !is_read_r}
            - {2'h0, write_retire && wr_cnt != 3'h0};
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_cnt <= sprqd_pkg::COUNT_RESET;
            wr_cnt <= sprqd_pkg::COUNT_RESET;
        end else begin
            rd_cnt <= rd_cnt_nxt;
            wr_cnt <= wr_cnt_nxt;
        end
    end

    assign reads_outstanding = rd_cnt;
    assign writes_outstanding = wr_cnt;
endmodule

// file: hw/sprqd_arbiter.sv
`timescale 1ns/1ns
module sprqd_arbiter (
    input wire logic clk,
    input wire logic reset_n,
    sprqd_if.arbiter_end link,
    input wire logic cmd_valid,
    input wire logic cmd_secondary,
    input wire logic cmd_read,
    input wire logic [1:0] cmd_index,
    input wire logic [1:0] cmd_width,
    input wire logic [3:0] cmd_size,
    input wire logic [15:0] cmd_byte_en,
    input wire logic [6:0] cmd_attr,
    input wire logic promote,
    output logic cmd_ready,
    output logic cmd_done,
    output logic cmd_failed
);
    ////////////////////////////////////////////////////////////////////////////
    // Request presentation held until acknowledge or error
    logic busy_r;
    logic busy_nxt;
    logic sec_r;
    logic rd_r;
    logic [1:0] index_r;
    logic [1:0] width_r;
    logic [3:0] size_r;
    logic [15:0] be_r;
    logic [6:0] attr_r;
    logic answer;
    logic take;

    assign answer = link.address_acknowledge || link.address_error;
    assign cmd_ready = !busy_r;
    assign take = cmd_valid && !busy_r;

    always_comb begin
        busy_nxt = busy_r;
        if (take) begin
            busy_nxt = 1'b1;
        end else if (answer) begin
            busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
            sec_r <= 1'b0;
            rd_r <= 1'b0;
            index_r <= 2'h0;
            width_r <= sprqd_pkg::WIDTH_64;
            size_r <= sprqd_pkg::SIZE_SINGLE;
            be_r <= 16'h0000;
            attr_r <= 7'h00;
        end else begin
            busy_r <= busy_nxt;
            if (take) begin
                sec_r <= cmd_secondary;
                rd_r <= cmd_read;
                index_r <= cmd_index;
                width_r <= cmd_width;
                size_r <= cmd_size;
                be_r <= cmd_byte_en;
                attr_r <= cmd_attr;
            end
        end
    end

    assign link.primary_addr_valid = busy_r && !sec_r;
    assign link.secondary_addr_valid = busy_r && sec_r;
    assign link.read_not_write = rd_r;
    assign link.requester_index = index_r;
    assign link.requester_width = width_r;
    assign link.transfer_size_code = size_r;
    assign link.byte_enable = be_r;
    assign link.requester_transfer_attribute = attr_r;
    assign link.read_pending_priority = index_r;
    assign link.read_pending_request = sec_r && rd_r;
    assign link.request_priority = index_r;
    assign link.read_promote = promote;
    assign cmd_done = busy_r && link.address_acknowledge;
    assign cmd_failed = busy_r && link.address_error;

    ////////////////////////////////////////////////////////////////////////////
    // Read burst indicator, one pending secondary burst remembered
    logic burst_ack;
    logic [4:0] units;
    logic [4:0] left_r;
    logic [4:0] left_nxt;
    logic [4:0] pend_r;
    logic [4:0] pend_nxt;

    assign burst_ack = cmd_done && rd_r && (size_r == sprqd_pkg::SIZE_BURST_WORD
        || size_r == sprqd_pkg::SIZE_BURST_DWORD);
    assign units = {1'b0, be_r[sprqd_pkg::BURST_COUNT_MSB:sprqd_pkg::BURST_COUNT_LSB]}
        + 5'h01;

    always_comb begin
        left_nxt = left_r;
        pend_nxt = pend_r;
        if (link.read_data_ack && left_r != 5'h00) begin
            left_nxt = left_r - 5'h01;
        end
        if (burst_ack && !sec_r) begin
            left_nxt = units;
        end else if (burst_ack) begin
            pend_nxt = units;
        end
        if (promote && left_r == 5'h00) begin
            left_nxt = pend_r;
            pend_nxt = 5'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            left_r <= sprqd_pkg::BEATS_RESET;
            pend_r <= sprqd_pkg::BEATS_RESET;
        end else begin
            left_r <= left_nxt;
            pend_r <= pend_nxt;
        end
    end

    // High through all beats but the last
    assign link.read_burst_active = left_r > 5'h01;
endmodule

// file: verif/sprqd_sva.sv
`timescale 1ns/1ns
module sprqd_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] requester_index,
    input wire logic [1:0] requester_width,
    input wire logic primary_addr_valid,
    input wire logic secondary_addr_valid,
    input wire logic [3:0] transfer_size_code,
    input wire logic [15:0] byte_enable,
    input wire logic address_acknowledge,
    input wire logic address_error
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    logic bad;
    assign bad = requester_width == sprqd_pkg::WIDTH_BAD
                 || !(transfer_size_code inside {4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb});

    // Request standing and not yet answered
    sequence s_wait;
        (primary_addr_valid || secondary_addr_valid) && !address_acknowledge && !address_error;
    endsequence
    sequence s_bad_req;
        s_wait ##0 (primary_addr_valid && bad);
    endsequence

    ack_cause_a: assert property (address_acknowledge
        |-> $past(primary_addr_valid || secondary_addr_valid))
        else $error("acknowledge without a request");
    ack_pulse_a: assert property (address_acknowledge
        |=> !address_acknowledge && !address_error)
        else $error("acknowledge longer than one cycle");
    err_pulse_a: assert property (address_error
        |=> !address_error && !address_acknowledge)
        else $error("error longer than one cycle");
    ack_err_excl_a: assert property (!(address_acknowledge && address_error))
        else $error("acknowledge and error together");
    bad_no_ack_a: assert property (s_bad_req |=> !address_acknowledge)
        else $error("illegal request acknowledged");
    bad_err_a: assert property (s_bad_req |-> ##[1:16] address_error)
        else $error("illegal request not flagged");
    good_no_err_a: assert property (s_wait ##0 !bad |=> !address_error)
        else $error("legal request flagged");
    qual_hold_a: assert property (s_wait
        |=> (primary_addr_valid || secondary_addr_valid) && $stable(transfer_size_code)
        && $stable(byte_enable) && $stable(requester_index))
        else $error("qualifiers changed before answer");
endmodule

// file: verif/slave_port_request_qualifier_decode_tb_top.sv
`timescale 1ns/1ns
module slave_port_request_qualifier_decode_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic pipeline_enable = 1'b1, read_beat = 1'b0, write_retire = 1'b0, promote = 1'b0;
    logic cmd_valid = 1'b0, cmd_secondary = 1'b0, cmd_read = 1'b0;
    logic [1:0] cmd_index = 2'h0, cmd_width = 2'h0;
    logic [3:0] cmd_size = 4'h0;
    logic [15:0] cmd_byte_en = 16'h0000;
    logic [6:0] cmd_attr = 7'h00;
    logic cmd_ready, cmd_done, cmd_failed, req_valid, req_error, req_is_read, req_secondary;
    logic req_write_through, req_cache_inhibit, req_coherent, req_guarded, primary_read_busy;
    logic [1:0] req_index, req_width;
    sprqd_pkg::sprqd_kind_t req_kind;
    logic [4:0] req_beats;
    logic [15:0] req_byte_en;
    logic [2:0] req_user_attr, reads_outstanding, writes_outstanding;
    logic [1:0] l_w;
    logic [3:0] l_sz;
    logic [15:0] l_be;
    logic [6:0] l_at;
    logic [1:0] l_idx;
    logic l_rd;
    logic [3:0] szt [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'h5, 4'hf};
    int fail_count = 0, compares = 0, seed = 19, rd_acks = 0, burst_hi = 0;
    bit got;

    sprqd_if ifc ();
    sprqd_port i_sprqd_port (.clk, .reset_n, .link(ifc), .pipeline_enable, .read_beat,
        .write_retire, .req_valid, .req_error, .req_is_read, .req_secondary, .req_index,
        .req_width, .req_kind, .req_beats, .req_byte_en, .req_write_through, .req_cache_inhibit,
        .req_coherent, .req_guarded, .req_user_attr, .primary_read_busy, .reads_outstanding,
        .writes_outstanding);
    sprqd_arbiter i_sprqd_arbiter (.clk, .reset_n, .link(ifc), .cmd_valid, .cmd_secondary,
        .cmd_read, .cmd_index, .cmd_width, .cmd_size, .cmd_byte_en, .cmd_attr, .promote,
        .cmd_ready, .cmd_done, .cmd_failed);
    sprqd_sva i_sprqd_sva (.clk, .reset_n, .requester_index(ifc.requester_index),
        .requester_width(ifc.requester_width), .primary_addr_valid(ifc.primary_addr_valid),
        .secondary_addr_valid(ifc.secondary_addr_valid),
        .transfer_size_code(ifc.transfer_size_code), .byte_enable(ifc.byte_enable),
        .address_acknowledge(ifc.address_acknowledge), .address_error(ifc.address_error));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (ifc.read_data_ack === 1'b1) begin
            rd_acks++;
        end
        if (ifc.read_data_ack === 1'b1 && ifc.read_burst_active === 1'b1) begin
            burst_hi++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            $display("FAIL %s expected %0h seen %0h", name, e, g);
            fail_count++;
        end
    endtask

    function automatic logic [4:0] exp_beats(logic [1:0] w, logic [3:0] sz, logic [15:0] be);
        case (sz)
            sprqd_pkg::SIZE_SINGLE: return 5'h01;
            sprqd_pkg::SIZE_LINE4: return sprqd_pkg::LINE4_WORDS >> w;
            sprqd_pkg::SIZE_LINE8: return sprqd_pkg::LINE8_WORDS >> w;
            sprqd_pkg::SIZE_LINE16: return sprqd_pkg::LINE16_WORDS >> w;
            default: return 5'(be[15:12]) + 5'h01;
        endcase
    endfunction

    function automatic logic [2:0] exp_kind(logic [3:0] sz);
        if (sz == sprqd_pkg::SIZE_SINGLE) begin
            return sprqd_pkg::SPRQD_KIND_SINGLE;
        end
        return (sz < 4'h4) ? sprqd_pkg::SPRQD_KIND_LINE : sprqd_pkg::SPRQD_KIND_BURST;
    endfunction

    task automatic send(input logic sec, input logic rd, input logic [1:0] w,
                        input logic [3:0] sz);
        l_idx = 2'($random(seed));
        l_be = 16'($random(seed));
        l_at = 7'($random(seed));
        {l_rd, l_w, l_sz} = {rd, w, sz};
        cmd_valid <= 1'b1;
        cmd_secondary <= sec;
        {cmd_read, cmd_index, cmd_width, cmd_size, cmd_byte_en, cmd_attr}
            <= {rd, l_idx, w, sz, l_be, l_at};
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask

    task automatic wait_ans(output bit ok);
        ok = 1'b0;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (req_valid === 1'b1 || req_error === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
    endtask

    task automatic verify();
        if (l_w == sprqd_pkg::WIDTH_BAD
                || !(l_sz inside {4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb})) begin
            check("error", 1, req_error);
            check("failed", 1, cmd_failed);
        end else begin
            check("done", 1, cmd_done);
            check("kind", exp_kind(l_sz), req_kind);
            check("beats", exp_beats(l_w, l_sz, l_be), req_beats);
            check("byte_en", l_be, req_byte_en);
            check("index", l_idx, req_index);
            check("width", l_w, req_width);
            check("read", l_rd, req_is_read);
            check("wimg", l_at[3:0],
                {req_guarded, req_coherent, req_cache_inhibit, req_write_through});
            check("user", l_at[6:4], req_user_attr);
        end
    endtask

    task automatic pulse(input bit rb);
        if (rb) read_beat <= 1'b1; else write_retire <= 1'b1;
        @(posedge clk);
        {read_beat, write_retire} <= 2'b00;
        @(posedge clk);
        #1;
    endtask

    task automatic drain(input int n, input int hi);
        int base;
        int base_hi;
        base = rd_acks;
        base_hi = burst_hi;
        repeat (n) pulse(1'b1);
        repeat (3) @(posedge clk);
        #1;
        check("data acks", 16'(n), 16'(rd_acks - base));
        check("burst beats", 16'(hi), 16'(burst_hi - base_hi));
        check("busy", 0, primary_read_busy);
    endtask

    task automatic do_req(input logic sec, input logic rd, input logic [1:0] w,
                          input logic [3:0] sz, input bit fin);
        int n;
        int hi;
        bit acked;
        send(sec, rd, w, sz);
        wait_ans(got);
        check("answer", 1, got);
        verify();
        acked = req_valid === 1'b1;
        n = exp_beats(w, sz, l_be);
        hi = (sz inside {sprqd_pkg::SIZE_BURST_WORD, sprqd_pkg::SIZE_BURST_DWORD}) ? n - 1 : 0;
        // Counts and read state take the acknowledge one edge later
        @(posedge clk);
        #1;
        if (fin && acked) begin
            if (rd) drain(n, hi); else pulse(1'b0);
            check("outstanding", 0, {reads_outstanding, writes_outstanding});
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #60000;
        fail_count++;
        $display("FAIL watchdog expected done seen timeout");
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            do_req(1'b0, i[0], 2'(i % 4), szt[i], 1'b1);
        end
        repeat (30) do_req(1'b0, 1'($random(seed)), 2'($random(seed)),
            szt[3'($random(seed))], 1'b1);
        $display("test decode done");
        repeat (4) do_req(1'b0, 1'b0, 2'h2, 4'h0, 1'b0);
        check("writes", 4, writes_outstanding);
        send(1'b0, 1'b0, 2'h2, 4'h0);
        wait_ans(got);
        check("fifth held", 0, got);
        write_retire <= 1'b1;
        @(posedge clk);
        write_retire <= 1'b0;
        wait_ans(got);
        check("fifth taken", 1, got);
        repeat (4) pulse(1'b0);
        check("writes", 0, writes_outstanding);
        $display("test write limit done");
        pipeline_enable <= 1'b0;
        send(1'b1, 1'b1, 2'h0, 4'h0);
        wait_ans(got);
        check("no pipelining", 0, got);
        pipeline_enable <= 1'b1;
        wait_ans(got);
        check("sec taken", 1, got);
        check("secondary", 1, req_secondary);
        do_req(1'b1, 1'b1, 2'h0, 4'h1, 1'b0);
        check("reads", 2, reads_outstanding);
        for (int n = 1; n <= 4; n += 3) begin
            promote <= 1'b1;
            @(posedge clk);
            promote <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            check("promoted", 1, primary_read_busy);
            drain(n, 0);
        end
        $display("test promote done");
        print_verdict();
    end
endmodule
